// file: ddtc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// Controller side of the link: drives the pin and write commands just after link_clk rises.
module ddtc_ctrl_model (
    input wire logic link_clk,
    output logic termination_pin,
    output logic cmd_write,
    output logic cmd_burst_full
);
    int high_cnt = 0;

    // The pin idles low and no command is pending at time zero.
    initial begin
        termination_pin = 1'b0;
        cmd_write = 1'b0;
        cmd_burst_full = 1'b0;
    end

    // Edges seen with the pin high, so the pin is never lowered early.
    always @(posedge link_clk) high_cnt <= termination_pin ? high_cnt + 1 : 0;

    // One write pulse with the pin level set beside it.
    task automatic issue(input logic pin, input logic wr, input logic full);
        @(posedge link_clk);
        #1;
        termination_pin = pin;
        cmd_write = wr;
        cmd_burst_full = full;
        @(posedge link_clk);
        #1;
        cmd_write = 1'b0;
        cmd_burst_full = ~full; // Stale once the command is taken, so show the inverse.
    endtask

    // Lowers the pin only after the minimum high time has passed.
    task automatic drop_pin(input int hold);
        while (high_cnt < hold) @(posedge link_clk);
        @(posedge link_clk);
        #1;
        termination_pin = 1'b0;
    endtask
endmodule

`default_nettype wire

// file: ddtc_pkg.sv
package ddtc_pkg;

    // Mode register word width and the termination fields inside it.
    localparam int MR_W = 18;
    localparam int TERM_W = 3;
    localparam int MR1_NOM_LSB = 8;
    localparam int MR2_WR_LSB = 9;
    localparam int MR5_PARK_LSB = 6;
    localparam int MR2_DYN_LO_BIT = 9;
    localparam int MR2_DYN_HI_BIT = 10;
    localparam logic [TERM_W-1:0] TERM_OFF = 3'h0;

    // Latency field widths.
    localparam int CWL_W = 5;
    localparam int AL_W = 5;
    localparam int PL_W = 3;
    localparam int LAT_W = 8;

    // Latency reduction for one- and two-cycle preambles.
    localparam logic [LAT_W-1:0] PRE1_SUB = 8'h02;
    localparam logic [LAT_W-1:0] PRE2_SUB = 8'h03;
    // Shortest latency applied when the subtraction would reach zero or wrap.
    localparam logic [LAT_W-1:0] LAT_MIN = 8'h01;

    // Write window length beyond the start latency.
    localparam logic [LAT_W-1:0] END_CHOP_P1_C0 = 8'h04;
    localparam logic [LAT_W-1:0] END_CHOP_P1_C1 = 8'h07;
    localparam logic [LAT_W-1:0] END_CHOP_P2_C0 = 8'h05;
    localparam logic [LAT_W-1:0] END_CHOP_P2_C1 = 8'h08;
    localparam logic [LAT_W-1:0] END_FULL_P1_C0 = 8'h06;
    localparam logic [LAT_W-1:0] END_FULL_P1_C1 = 8'h07;
    localparam logic [LAT_W-1:0] END_FULL_P2_C0 = 8'h07;
    localparam logic [LAT_W-1:0] END_FULL_P2_C1 = 8'h08;

    // Burst length modes.
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    // History depth covers the longest window end plus margin.
    localparam int HIST_DEPTH = 128;
    localparam int IDX_W = 7;

    // Configuration word carried across to the link domain.
    localparam int CFG_W = 3 * TERM_W + 1 + CWL_W + AL_W + PL_W + 3 + 2;

    // Termination source currently applied.
    typedef enum logic [1:0] {
        SRC_PARK,
        SRC_NOM,
        SRC_WRITE
    } ddtc_src_e;

endpackage

// file: ddtc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser; the first stage feeds only the second.
module ddtc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Both stages clear together under the synchronous reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule
`default_nettype wire

// file: ddtc_term_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module ddtc_term_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic [ddtc_pkg::MR_W-1:0] mr1_word,
    input wire logic [ddtc_pkg::MR_W-1:0] mr2_word,
    input wire logic [ddtc_pkg::MR_W-1:0] mr5_word,
    input wire logic [ddtc_pkg::CWL_W-1:0] cwl,
    input wire logic [ddtc_pkg::AL_W-1:0] al,
    input wire logic [ddtc_pkg::PL_W-1:0] pl,
    input wire logic preamble_2ck,
    input wire logic crc_on,
    input wire logic [1:0] bl_mode,
    input wire logic dll_off,
    input wire logic termination_pin,
    input wire logic cmd_write,
    input wire logic cmd_burst_full,
    output ddtc_pkg::ddtc_src_e term_src,
    output logic [ddtc_pkg::TERM_W-1:0] term_code,
    output logic sts_write_window,
    output logic sts_nominal_on,
    output logic cfg_busy
);
    import ddtc_pkg::*;

    // True when any history bit between lo (inclusive) and hi (exclusive) is set.
    function automatic logic hist_hit(input logic [HIST_DEPTH-1:0] hist, input logic [IDX_W-1:0] lo,
                                      input logic [IDX_W-1:0] hi);
        logic hit;
        hit = 1'h0;
        for (int j = 0; j < HIST_DEPTH; j++) begin
            if (j >= lo && j < hi && hist[j]) begin
                hit = 1'h1;
            end
        end
        return hit;
    endfunction

    // History tap for a latency; a latency below one cycle is treated as one.
    function automatic logic [IDX_W-1:0] lat_tap(input logic [LAT_W-1:0] lat);
        logic [LAT_W-1:0] t;
        t = (lat == '0) ? '0 : lat - 8'h01;
        return t[IDX_W-1:0];
    endfunction

    // Window length beyond the start, by burst, preamble and CRC.
    function automatic logic [LAT_W-1:0] end_extra(input logic chop, input logic pre2, input logic crc);
        logic [LAT_W-1:0] e;
        case ({chop, pre2, crc})
            3'h0: e = END_FULL_P1_C0;
            3'h1: e = END_FULL_P1_C1;
            3'h2: e = END_FULL_P2_C0;
            3'h3: e = END_FULL_P2_C1;
            3'h4: e = END_CHOP_P1_C0;
            3'h5: e = END_CHOP_P1_C1;
            3'h6: e = END_CHOP_P2_C0;
            default: e = END_CHOP_P2_C1;
        endcase
        return e;
    endfunction

    // ---------------- System clock side: config capture and handshake ----------------

    logic [CFG_W-1:0] cfg_now;
    logic [CFG_W-1:0] cfg_hold_reg;
    logic [CFG_W-1:0] cfg_hold_next;
    logic req_tgl_reg;
    logic req_tgl_next;
    logic ack_sys;
    logic cfg_pending;
    logic dyn_bits;

    // Field extraction from the mode register words.
    assign dyn_bits = mr2_word[MR2_DYN_LO_BIT] | mr2_word[MR2_DYN_HI_BIT];
    assign cfg_now = {mr1_word[MR1_NOM_LSB +: TERM_W], mr2_word[MR2_WR_LSB +: TERM_W],
                      mr5_word[MR5_PARK_LSB +: TERM_W], dyn_bits, cwl, al, pl,
                      preamble_2ck, crc_on, dll_off, bl_mode};

    // A new word is only loaded once the link side has acknowledged the last one,
    // so the holding register is stable whenever the link side reads it.
    assign cfg_pending = req_tgl_reg != ack_sys;
    assign cfg_hold_next = (!cfg_pending && cfg_now != cfg_hold_reg) ? cfg_now : cfg_hold_reg;
    assign req_tgl_next = (!cfg_pending && cfg_now != cfg_hold_reg) ? ~req_tgl_reg : req_tgl_reg;

    // Handshake source registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_hold_reg <= '0;
            req_tgl_reg <= 1'h0;
        end else begin
            cfg_hold_reg <= cfg_hold_next;
            req_tgl_reg <= req_tgl_next;
        end
    end

    assign cfg_busy = cfg_pending || (cfg_now != cfg_hold_reg);

    // ---------------- Link clock side ----------------

    logic lrst_n;
    logic req_link;
    logic ack_tgl_reg;
    logic [CFG_W-1:0] cfg_l_reg;
    logic [CFG_W-1:0] cfg_l_next;
    logic [TERM_W-1:0] l_nom;
    logic [TERM_W-1:0] l_wr;
    logic [TERM_W-1:0] l_park;
    logic l_dyn;
    logic [CWL_W-1:0] l_cwl;
    logic [AL_W-1:0] l_al;
    logic [PL_W-1:0] l_pl;
    logic l_pre2;
    logic l_crc;
    logic l_dll_off;
    logic [1:0] l_bl;

    // Reset release reaches the link domain through its own synchroniser.
    ddtc_sync #(.WIDTH(1)) u_link_rst (
        .clk(link_clk),
        .rst_n(1'h1),
        .d(rst_n),
        .q(lrst_n)
    );

    ddtc_sync #(.WIDTH(1)) u_req_sync (
        .clk(link_clk),
        .rst_n(lrst_n),
        .d(req_tgl_reg),
        .q(req_link)
    );

    ddtc_sync #(.WIDTH(1)) u_ack_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(ack_tgl_reg),
        .q(ack_sys)
    );

    assign cfg_l_next = (req_link != ack_tgl_reg) ? cfg_hold_reg : cfg_l_reg;

    // Configuration receiver: load on a request edge, then acknowledge.
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            cfg_l_reg <= '0;
            ack_tgl_reg <= 1'h0;
        end else begin
            cfg_l_reg <= cfg_l_next;
            ack_tgl_reg <= req_link;
        end
    end

    assign {l_nom, l_wr, l_park, l_dyn, l_cwl, l_al, l_pl, l_pre2, l_crc, l_dll_off, l_bl} = cfg_l_reg;

    logic dyn_en;
    logic [LAT_W-1:0] wl_sum;
    logic [LAT_W-1:0] pre_sub;
    logic [LAT_W-1:0] start_lat;
    logic [LAT_W-1:0] end_full_lat;
    logic [LAT_W-1:0] end_chop_lat;
    logic [IDX_W-1:0] start_tap;
    logic [IDX_W-1:0] full_tap;
    logic [IDX_W-1:0] chop_tap;
    logic cmd_chop;
    logic wr_take;

    // Write-time switching needs the enable bits and a running loop; a zero
    // write field written by the controller clears the enable bits.
    assign dyn_en = l_dyn && !l_dll_off;

    // Write latency sum; direct pin latency equals the write start latency.
    assign wl_sum = LAT_W'(l_cwl) + LAT_W'(l_al) + LAT_W'(l_pl);
    // Small latency sums would wrap below zero, so they are clamped to one cycle.
    assign pre_sub = l_pre2 ? PRE2_SUB : PRE1_SUB;
    assign start_lat = (wl_sum > pre_sub) ? wl_sum - pre_sub : LAT_MIN;
    assign end_full_lat = start_lat + end_extra(1'h0, l_pre2, l_crc);
    assign end_chop_lat = start_lat + end_extra(1'h1, l_pre2, l_crc);
    assign start_tap = lat_tap(start_lat);
    assign full_tap = lat_tap(end_full_lat);
    assign chop_tap = lat_tap(end_chop_lat);

    // Chopped burst when fixed to four beats or chosen on the fly per command.
    assign cmd_chop = (l_bl == BL_FIXED4) || (l_bl == BL_OTF && !cmd_burst_full);
    assign wr_take = cmd_write && dyn_en;

    logic [HIST_DEPTH-1:0] pin_hist_reg;
    logic [HIST_DEPTH-1:0] full_hist_reg;
    logic [HIST_DEPTH-1:0] chop_hist_reg;
    logic [HIST_DEPTH-1:0] pin_hist_next;
    logic [HIST_DEPTH-1:0] full_hist_next;
    logic [HIST_DEPTH-1:0] chop_hist_next;

    // Shift histories; bit j holds what was sampled j+1 edges before now.
    assign pin_hist_next = {pin_hist_reg[HIST_DEPTH-2:0], termination_pin};
    assign full_hist_next = {full_hist_reg[HIST_DEPTH-2:0], wr_take && !cmd_chop};
    assign chop_hist_next = {chop_hist_reg[HIST_DEPTH-2:0], wr_take && cmd_chop};

    // History registers; the pin arrives on the link clock and needs no synchroniser.
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            pin_hist_reg <= '0;
            full_hist_reg <= '0;
            chop_hist_reg <= '0;
        end else begin
            pin_hist_reg <= pin_hist_next;
            full_hist_reg <= full_hist_next;
            chop_hist_reg <= chop_hist_next;
        end
    end

    logic win_hit;
    logic pin_eff;
    logic nom_on;
    ddtc_src_e src_next;
    ddtc_src_e src_reg;
    logic [TERM_W-1:0] code_next;
    logic [TERM_W-1:0] code_reg;

    // Overlapping writes stretch the window since every write keeps its own age.
    assign win_hit = dyn_en && (hist_hit(full_hist_reg, start_tap, full_tap) ||
                                hist_hit(chop_hist_reg, start_tap, chop_tap));

    // Loop off: the pin acts on the next edge with no additive or parity delay.
    // Loop on: the pin is taken from history at the direct latency.
    assign pin_eff = l_dll_off ? termination_pin : pin_hist_reg[start_tap];
    assign nom_on = pin_eff && (l_nom != TERM_OFF);

    // Priority: write window, then nominal, then parked.
    assign src_next = win_hit ? SRC_WRITE : (nom_on ? SRC_NOM : SRC_PARK);
    assign code_next = win_hit ? l_wr : (nom_on ? l_nom : l_park);

    // Termination output registers.
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            src_reg <= SRC_PARK;
            code_reg <= TERM_OFF;
        end else begin
            src_reg <= src_next;
            code_reg <= code_next;
        end
    end

    assign term_src = src_reg;
    assign term_code = code_reg;

    logic [1:0] sts_sys;

    // Status levels back to the system clock; each bit is an independent level.
    ddtc_sync #(.WIDTH(2)) u_sts_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({src_reg == SRC_WRITE, src_reg == SRC_NOM}),
        .q(sts_sys)
    );

    assign sts_write_window = sts_sys[1];
    assign sts_nominal_on = sts_sys[0];

    // ---------------- Checks on the link side ----------------

    logic cfg_steady;
    assign cfg_steady = cfg_l_next == cfg_l_reg;

    chk_write_override: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (win_hit && termination_pin) |=> (term_src == SRC_WRITE && term_code == $past(l_wr)))
        else $error("write window did not override nominal termination");

    chk_enable_bits: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (term_src == SRC_WRITE) |-> $past(l_dyn))
        else $error("write termination without enable bits");

    chk_no_write_dll: assert property (@(posedge link_clk) disable iff (!lrst_n)
        ($past(l_dll_off) && l_dll_off) |-> term_src != SRC_WRITE)
        else $error("write termination while loop off");

    chk_code_source: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (cfg_steady && $stable(cfg_l_reg) && term_src == SRC_PARK) |-> term_code == l_park)
        else $error("parked code does not match field");

    chk_async_on: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (l_dll_off && cfg_steady && termination_pin && l_nom != TERM_OFF) |=> term_src == SRC_NOM)
        else $error("asynchronous turn-on missed");

    chk_async_off: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (l_dll_off && cfg_steady && !termination_pin) |=> term_src == SRC_PARK)
        else $error("asynchronous turn-off missed");

    chk_nom_disabled: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (l_nom == TERM_OFF && cfg_steady) |=> term_src != SRC_NOM)
        else $error("nominal on while field disabled");

    chk_start_latency: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (cmd_write && dyn_en && !l_pre2 && l_cwl == 5'h09 && l_al == '0 && l_pl == '0 && cfg_steady)
        [*1] ##0 (cfg_steady [*1]) |=> ##7 term_src == SRC_WRITE)
        else $error("write termination not started at write latency minus two");

    chk_chop_extra: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (!l_pre2 && !l_crc) |-> (end_chop_lat - start_lat == 8'h04 && end_full_lat - start_lat == 8'h06))
        else $error("window length table mismatch");

    chk_sync_follow: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (!l_dll_off && !win_hit && pin_hist_reg[start_tap] && l_nom != TERM_OFF) |=> term_src == SRC_NOM)
        else $error("delayed pin did not select nominal");

    cov_write_window: cover property (@(posedge link_clk) disable iff (!lrst_n)
        $rose(term_src == SRC_WRITE));

    cov_chop_write: cover property (@(posedge link_clk) disable iff (!lrst_n)
        cmd_write && dyn_en && cmd_chop);

    cov_overlap_nom: cover property (@(posedge link_clk) disable iff (!lrst_n)
        term_src == SRC_NOM ##1 term_src == SRC_WRITE ##[1:20] term_src == SRC_NOM);

    cov_async_nom: cover property (@(posedge link_clk) disable iff (!lrst_n)
        l_dll_off && term_src == SRC_NOM);

endmodule
`default_nettype wire

// file: tb_dram_dynamic_termination_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dram_dynamic_termination_ctrl;
    import ddtc_pkg::*;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [MR_W-1:0] mr1_word = '0;
    logic [MR_W-1:0] mr2_word = '0;
    logic [MR_W-1:0] mr5_word = '0;
    logic [CWL_W-1:0] cwl = '0;
    logic [AL_W-1:0] al = '0;
    logic [PL_W-1:0] pl = '0;
    logic preamble_2ck = 1'b0;
    logic crc_on = 1'b0;
    logic [1:0] bl_mode = 2'h0;
    logic dll_off = 1'b0;
    logic termination_pin;
    logic cmd_write;
    logic cmd_burst_full;
    ddtc_src_e term_src;
    logic [TERM_W-1:0] term_code;
    logic sts_write_window;
    logic sts_nominal_on;
    logic cfg_busy;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    // The link clock is started off an odd phase so the two domains never line up.
    always #12.5 clk = ~clk;
    initial begin
        #3.7;
        forever #6 link_clk = ~link_clk;
    end

    ddtc_term_ctrl u_dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .mr1_word(mr1_word),
        .mr2_word(mr2_word), .mr5_word(mr5_word), .cwl(cwl), .al(al), .pl(pl), .preamble_2ck(preamble_2ck),
        .crc_on(crc_on), .bl_mode(bl_mode), .dll_off(dll_off), .termination_pin(termination_pin),
        .cmd_write(cmd_write), .cmd_burst_full(cmd_burst_full), .term_src(term_src), .term_code(term_code),
        .sts_write_window(sts_write_window), .sts_nominal_on(sts_nominal_on), .cfg_busy(cfg_busy));

    ddtc_ctrl_model u_ctrl (.link_clk(link_clk), .termination_pin(termination_pin), .cmd_write(cmd_write),
        .cmd_burst_full(cmd_burst_full));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A hang anywhere ends the run as a failure.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // Window length beyond the start latency, by burst, preamble and CRC.
    function automatic int end_len(input logic full, input logic pre, input logic crc);
        if (full) return crc ? (pre ? 8 : 7) : (pre ? 7 : 6);
        return crc ? (pre ? 8 : 7) : (pre ? 5 : 4);
    endfunction

    // Expected value applied for a given source.
    function automatic logic [TERM_W-1:0] code_of(input ddtc_src_e src);
        if (src == SRC_WRITE) return mr2_word[MR2_WR_LSB +: TERM_W];
        if (src == SRC_NOM) return mr1_word[MR1_NOM_LSB +: TERM_W];
        return mr5_word[MR5_PARK_LSB +: TERM_W];
    endfunction

    // One configuration, one write with the pin set, then the pin lowered; flags are {dll, full, crc, pre}.
    task automatic run_op(input int c, input int a, input int p, input logic [3:0] flags, input logic [1:0] blm,
                          input logic [2:0] nomf, input logic [2:0] wrf, input logic pin);
        int s;
        int x;
        int lat;
        logic wen;
        ddtc_src_e es;
        @(posedge clk);
        #1;
        cwl = CWL_W'(c);
        al = AL_W'(a);
        pl = PL_W'(p);
        {dll_off, crc_on, preamble_2ck} = {flags[3], flags[1:0]};
        bl_mode = blm;
        mr1_word = MR_W'($urandom);
        mr1_word[MR1_NOM_LSB +: TERM_W] = nomf;
        mr2_word = MR_W'($urandom);
        mr2_word[MR2_WR_LSB +: TERM_W] = wrf;
        mr5_word = MR_W'($urandom);
        repeat (2) @(posedge clk);
        for (int i = 0; i < 60 && cfg_busy !== 1'b0; i++) @(posedge clk);
        s = c + a + p - (flags[0] ? 3 : 2);
        if (s < 1) s = 1;
        x = end_len(blm == BL_FIXED8 || (blm == BL_OTF && flags[2]), flags[0], flags[1]);
        wen = (wrf[1:0] != 2'h0) && !flags[3];
        lat = flags[3] ? 0 : s;
        u_ctrl.issue(pin, 1'b1, flags[2]);
        for (int k = 0; k < s + x + 3; k++) begin
            @(negedge link_clk);
            if (wen && k >= s && k < s + x) es = SRC_WRITE;
            else if (pin && k >= lat && nomf != 3'h0) es = SRC_NOM;
            else es = SRC_PARK;
            check(8'(term_src), 8'(es), "source in write");
            check(8'(term_code), 8'(code_of(es)), "code in write");
        end
        repeat (5) @(posedge clk);
        #1;
        check(8'(sts_nominal_on), 8'(es == SRC_NOM), "nominal status");
        if (pin) begin
            u_ctrl.drop_pin((x > 5 ? 6 : 4) + int'(flags[0]));
            for (int k = 0; k <= lat + 1; k++) begin
                @(negedge link_clk);
                es = (k <= lat && nomf != 3'h0) ? SRC_NOM : SRC_PARK;
                check(8'(term_src), 8'(es), "source after pin low");
            end
        end
        repeat (8) @(negedge link_clk);
    endtask

    // Hand-picked corners first, then every burst mode and table entry, then a random mix.
    initial begin
        void'($urandom(32'h8bd671b3));
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        run_op(9, 0, 0, 4'b0100, BL_FIXED8, 3'h1, 3'h2, 1'b0);
        run_op(9, 10, 0, 4'b0000, BL_FIXED4, 3'h3, 3'h1, 1'b1);
        run_op(1, 0, 0, 4'b0001, BL_FIXED8, 3'h2, 3'h3, 1'b1);
        run_op(11, 0, 0, 4'b0100, BL_FIXED8, 3'h2, 3'h4, 1'b1);
        run_op(11, 0, 0, 4'b0100, BL_FIXED8, 3'h2, 3'h0, 1'b0);
        run_op(9, 3, 2, 4'b1100, BL_FIXED8, 3'h5, 3'h6, 1'b1);
        run_op(10, 1, 1, 4'b0000, BL_FIXED8, 3'h0, 3'h7, 1'b1);
        for (int i = 0; i < 12; i++) begin
            run_op(9 + $urandom % 12, $urandom % 4, $urandom % 5, {1'b0, 1'($urandom), 2'(i)}, 2'(i / 4),
                   3'($urandom), {1'($urandom), 2'($urandom) | 2'h1}, 1'($urandom));
        end
        for (int i = 0; i < 24; i++) begin
            run_op(9 + $urandom % 12, $urandom % 4, $urandom % 5, 4'($urandom), 2'($urandom % 3),
                   3'($urandom), 3'($urandom), 1'($urandom));
        end
        tally_and_finish();
    end
endmodule

`default_nettype wire
